// ---- common/cfe_pkg.sv ----
// Constants and types for the fetch/execute core
package cfe_pkg;
    localparam int PC_W = 9;
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam logic [PC_W-1:0] RESET_VECTOR = 9'h1ff;
    localparam logic [FADDR_W-1:0] ADDR_TIMER = 5'h01;
    localparam logic [FADDR_W-1:0] ADDR_PCL = 5'h02;
    localparam logic [FADDR_W-1:0] ADDR_STATUS = 5'h03;
    localparam int BIT_C = 0;
    localparam int BIT_DC = 1;
    localparam int BIT_Z = 2;
    localparam logic [INSN_W-1:0] INSN_NOP = 12'h000;
    // Phase encoding, Gray order along the cycle
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR  = 2'b10
    } cfe_phase_type;
    // ALU operation selector
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD  = 4'h1,
        OP_SUB  = 4'h2,
        OP_AND  = 4'h3,
        OP_IOR  = 4'h4,
        OP_XOR  = 4'h5,
        OP_RLF  = 4'h6,
        OP_RRF  = 4'h7,
        OP_MOV  = 4'h8,
        OP_CLR  = 4'h9,
        OP_COM  = 4'ha,
        OP_INC  = 4'hb,
        OP_DEC  = 4'hc,
        OP_SWAP = 4'hd
    } cfe_op_type;
endpackage : cfe_pkg

// ---- rtl/cfe_alu.sv ----
// Eight-bit ALU with carry, digit carry and zero outputs
`timescale 1ns/100ps
`default_nettype none
module cfe_alu
    import cfe_pkg::*;
(
    // Operands
    input  wire logic [DATA_W-1:0] a,
    input  wire logic [DATA_W-1:0] b,
    input  wire logic              carry_in,
    input  wire cfe_op_type        op,
    // Result
    output logic      [DATA_W-1:0] result,
    output logic                   carry_out,
    output logic                   digit_carry_out,
    output logic                   zero_out
);
    logic [DATA_W:0] sum;
    logic [4:0]      nib;
    always_comb begin
        sum = '0;
        nib = '0;
        result = b;
        carry_out = carry_in;
        digit_carry_out = 1'b0;
        case (op)
            OP_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                result = sum[DATA_W-1:0];
                carry_out = sum[DATA_W];
                digit_carry_out = nib[4];
            end
            OP_SUB: begin
                // Two's complement b - a; carries read as inverted borrows
                sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
                nib = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                result = sum[DATA_W-1:0];
                carry_out = sum[DATA_W];
                digit_carry_out = nib[4];
            end
            OP_AND:  result = a & b;
            OP_IOR:  result = a | b;
            OP_XOR:  result = a ^ b;
            OP_RLF: begin
                result = {b[DATA_W-2:0], carry_in};
                carry_out = b[DATA_W-1];
            end
            OP_RRF: begin
                result = {carry_in, b[DATA_W-1:1]};
                carry_out = b[0];
            end
            OP_MOV:  result = b;
            OP_CLR:  result = '0;
            OP_COM:  result = ~b;
            OP_INC:  result = b + 8'h01;
            OP_DEC:  result = b - 8'h01;
            OP_SWAP: result = {b[3:0], b[7:4]};
            default: result = b;
        endcase
        zero_out = (result == '0);
    end
endmodule : cfe_alu
`default_nettype wire

// ---- rtl/cfe_core.sv ----
// Four-phase fetch/execute core with two-stage pipeline
`timescale 1ns/100ps
`default_nettype none
module cfe_core
    import cfe_pkg::*;
#(
    parameter int PROG_ADDR_W = PC_W
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 master_clear_n,
    // Program memory
    output logic      [PC_W-1:0]      prog_addr,
    input  wire logic [INSN_W-1:0]    prog_data,
    // Data register file
    output logic      [FADDR_W-1:0]   data_addr,
    output logic                      data_rd,
    input  wire logic [DATA_W-1:0]    data_rdata,
    output logic                      data_wr,
    output logic      [DATA_W-1:0]    data_wdata,
    // Decoded instruction from the decoder
    input  wire cfe_op_type           dec_op,
    input  wire logic                 dec_use_literal,
    input  wire logic [DATA_W-1:0]    dec_literal,
    input  wire logic                 dec_dest_file,
    input  wire logic                 dec_affects_flags,
    input  wire logic                 dec_branch,
    input  wire logic [PC_W-1:0]      dec_target,
    // Clock output and timer
    input  wire logic                 rc_mode,
    input  wire logic [DATA_W-1:0]    timer_zero_count,
    output logic                      osc_output_clock_out,
    // Status
    output logic      [FADDR_W-1:0]   insn_file_addr,
    output logic      [INSN_W-1:0]    instruction_latch,
    output logic      [DATA_W-1:0]    working_register,
    output logic                      carry_flag,
    output logic                      digit_carry_flag,
    output logic                      zero_flag,
    output cfe_phase_type             phase
);
    // Counter and fetch bus share one width; anything else is refused
    if (PROG_ADDR_W != PC_W) begin : g_bad_width
        $error("cfe_core: program address width must equal PC_W");
    end

    logic          mclr_meta;
    logic          mclr_sync;
    logic          core_reset;
    logic [PC_W-1:0] pc;
    logic          exec_valid;
    logic          fetch_valid;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] alu_a;
    logic [DATA_W-1:0] alu_result;
    logic          alu_c;
    logic          alu_dc;
    logic          alu_z;
    logic          do_branch;
    logic [PC_W-1:0] next_pc;

    function automatic logic is_addr(input logic [FADDR_W-1:0] a,
                                     input logic [FADDR_W-1:0] r);
        return a == r;
    endfunction

    // Master clear is a pin: synchronise before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mclr_meta <= 1'b0;
            mclr_sync <= 1'b0;
        end else begin
            mclr_meta <= master_clear_n;
            mclr_sync <= mclr_meta;
        end
    end
    assign core_reset = !mclr_sync;

    // Phase sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_ONE;
        end else if (core_reset) begin
            phase <= PH_ONE;
        end else begin
            case (phase)
                PH_ONE:   phase <= PH_TWO;
                PH_TWO:   phase <= PH_THREE;
                PH_THREE: phase <= PH_FOUR;
                PH_FOUR:  phase <= PH_ONE;
                default:  phase <= PH_ONE;
            endcase
        end
    end

    assign do_branch = exec_valid && dec_branch;
    // Writes to 02h load the low byte; the top bit clears
    always_comb begin
        next_pc = pc + 9'h001;
        if (do_branch)
            next_pc = dec_target;
        else if (exec_valid && dec_dest_file && is_addr(insn_file_addr, ADDR_PCL))
            next_pc = {1'b0, alu_result};
    end

    // Counter: steps at end of phase four, redirected at end of execute
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= RESET_VECTOR;
        end else if (core_reset) begin
            pc <= RESET_VECTOR;
        end else if (phase == PH_FOUR) begin
            pc <= next_pc;
        end
    end

    // Fetch address is the counter one clock late: new from phase two to the next phase one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr <= RESET_VECTOR;
        end else begin
            prog_addr <= pc;
        end
    end

    // Instruction latch and pipeline validity
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instruction_latch <= INSN_NOP;
            insn_file_addr    <= '0;
            fetch_valid       <= 1'b0;
            exec_valid        <= 1'b0;
        end else if (core_reset) begin
            instruction_latch <= INSN_NOP;
            insn_file_addr    <= '0;
            fetch_valid       <= 1'b0;
            exec_valid        <= 1'b0;
        end else if (phase == PH_FOUR) begin
            instruction_latch <= prog_data;
            insn_file_addr    <= prog_data[FADDR_W-1:0];
            // Branch kills the word fetched behind it
            fetch_valid       <= 1'b1;
            // Word at the reset vector runs too; only a branch voids a fetch
            exec_valid        <= !do_branch;
        end
    end

    // Operand read in phase two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operand <= '0;
        end else if (phase == PH_TWO && exec_valid) begin
            if (is_addr(insn_file_addr, ADDR_PCL))
                operand <= pc[DATA_W-1:0];
            else if (is_addr(insn_file_addr, ADDR_STATUS))
                operand <= {5'h00, zero_flag, digit_carry_flag, carry_flag};
            else
                operand <= data_rdata;
        end
    end

    assign alu_a = dec_use_literal ? dec_literal : working_register;

    cfe_alu u_alu (
        .a               (alu_a),
        .b               (dec_use_literal ? working_register : operand),
        .carry_in        (carry_flag),
        .op              (dec_op),
        .result          (alu_result),
        .carry_out       (alu_c),
        .digit_carry_out (alu_dc),
        .zero_out        (alu_z)
    );

    // Data bus strobes: read in phase two, write in phase four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_addr  <= '0;
            data_rd    <= 1'b0;
            data_wr    <= 1'b0;
            data_wdata <= '0;
        end else begin
            data_addr  <= insn_file_addr;
            data_rd    <= exec_valid && (phase == PH_ONE);
            data_wr    <= exec_valid && (phase == PH_THREE) && dec_dest_file
                          && (dec_op != OP_NONE);
            data_wdata <= alu_result;
        end
    end

    // Working register: no data address reaches it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register <= '0;
        end else if (core_reset) begin
            working_register <= '0;
        end else if (phase == PH_FOUR && exec_valid && !dec_dest_file
                     && dec_op != OP_NONE) begin
            working_register <= alu_result;
        end
    end

    // Flags: hardware result beats a file write to status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_flag       <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag        <= 1'b0;
        end else if (phase == PH_FOUR && exec_valid) begin
            if (dec_affects_flags) begin
                carry_flag       <= alu_c;
                digit_carry_flag <= alu_dc;
                zero_flag        <= alu_z;
            end else if (dec_dest_file && is_addr(insn_file_addr, ADDR_STATUS)) begin
                carry_flag       <= alu_result[BIT_C];
                digit_carry_flag <= alu_result[BIT_DC];
                zero_flag        <= alu_result[BIT_Z];
            end
        end
    end

    // Clock output: timer bit 0 in RC mode, else cycle clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_output_clock_out <= 1'b0;
        end else if (rc_mode) begin
            osc_output_clock_out <= timer_zero_count[0];
        end else begin
            osc_output_clock_out <= (phase == PH_THREE) || (phase == PH_FOUR);
        end
    end

    a_phase_order: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        phase == PH_FOUR |=> phase == PH_ONE ##1 phase == PH_TWO)
        else $error("phase sequence broken");
    a_pc_step: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        (phase == PH_FOUR && !do_branch && !(exec_valid && dec_dest_file))
        |=> pc == $past(pc) + 9'h001)
        else $error("counter did not step");
    a_pc_wrap: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        (phase == PH_FOUR && pc == RESET_VECTOR && !exec_valid) |=> pc == 9'h000)
        else $error("counter did not wrap");
    a_branch_flush: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        (phase == PH_FOUR && do_branch) |=> !exec_valid [*4])
        else $error("branch did not flush");
    a_branch_target: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        (phase == PH_FOUR && do_branch) |=> pc == $past(dec_target))
        else $error("branch target not loaded");
    a_read_phase: assert property (@(posedge clk) disable iff (!rst_n)
        data_rd |-> phase == PH_TWO)
        else $error("read outside phase two");
    a_write_phase: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr |-> phase == PH_FOUR)
        else $error("write outside phase four");
    a_reset_vector: assert property (@(posedge clk) disable iff (!rst_n)
        core_reset |=> pc == RESET_VECTOR && !exec_valid && !fetch_valid)
        else $error("reset did not restart core");
    a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (phase == PH_FOUR && !exec_valid) |=> $stable(carry_flag) && $stable(zero_flag))
        else $error("flags changed without execution");
    a_rc_clkout: assert property (@(posedge clk) disable iff (!rst_n)
        rc_mode |=> osc_output_clock_out == $past(timer_zero_count[0]))
        else $error("clock output not from timer bit");
    a_pc_hold: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        phase != PH_FOUR |=> $stable(pc))
        else $error("counter moved outside phase four");
    a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        phase != PH_FOUR |=> $stable(instruction_latch))
        else $error("latch changed outside phase four");
    a_vector_runs: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        (phase == PH_FOUR && pc == RESET_VECTOR && !exec_valid) |=> exec_valid)
        else $error("word at reset vector not executed");
    a_wreg_hold: assert property (@(posedge clk) disable iff (!rst_n || core_reset)
        phase != PH_FOUR |=> $stable(working_register))
        else $error("working register changed outside phase four");
    a_read_before_write: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr |-> $past(data_rd, 2))
        else $error("write without operand read");

    c_branch: cover property (@(posedge clk) disable iff (!rst_n)
        phase == PH_FOUR && do_branch);
    c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        phase == PH_FOUR && pc == RESET_VECTOR);
    c_file_write: cover property (@(posedge clk) disable iff (!rst_n) data_wr);
    c_rc_mode: cover property (@(posedge clk) disable iff (!rst_n)
        rc_mode && osc_output_clock_out);
endmodule : cfe_core
`default_nettype wire

// ---- verification/cfe_mem_model.sv ----
// Program store and data register file facing the core
`timescale 1ns/100ps
`default_nettype none
module cfe_mem_model
    import cfe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Program side
    input  wire logic [PC_W-1:0]   prog_addr,
    output logic      [INSN_W-1:0] prog_data,
    // Data side
    input  wire logic [FADDR_W-1:0] data_addr,
    input  wire logic              data_rd,
    output logic      [DATA_W-1:0] data_rdata,
    input  wire logic              data_wr,
    input  wire logic [DATA_W-1:0] data_wdata
);
    logic [INSN_W-1:0] rom [0:511];
    logic [DATA_W-1:0] regs [0:31];
    logic [DATA_W-1:0] last_rd;
    // Whole word per access on its own bus
    assign prog_data = rom[prog_addr];
    // Released bus shows inverted last value, never a stale match
    assign data_rdata = data_rd ? regs[data_addr] : ~last_rd;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_rd <= 8'h5a;
        end else begin
            if (data_rd) last_rd <= regs[data_addr];
            if (data_wr) regs[data_addr] <= data_wdata;
        end
    end
endmodule // cfe_mem_model
`default_nettype wire

// ---- verification/tb_core_fetch_execute_pipeline.sv ----
// Self-checking bench for the fetch/execute core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_core_fetch_execute_pipeline;
    import cfe_pkg::*;
    logic clk, rst_n, master_clear_n, rc_mode, data_rd, data_wr;
    logic [DATA_W-1:0] timer_zero_count, data_rdata, data_wdata, working_register;
    logic [PC_W-1:0] prog_addr;
    logic [INSN_W-1:0] prog_data, instruction_latch;
    logic [FADDR_W-1:0] data_addr;
    logic osc_output_clock_out, carry_flag, digit_carry_flag, zero_flag;
    cfe_phase_type phase, pprev;
    cfe_op_type dec_op;
    logic dec_use_literal, dec_dest_file, dec_affects_flags, dec_branch;
    logic [DATA_W-1:0] dec_literal, mr [0:31], ew;
    logic [PC_W-1:0] dec_target;
    logic ec, edc, ez, prev_t;
    logic [12:0] expq [$];
    logic [12:0] wexp;
    logic [31:0] seed = 32'h18;
    int n_mismatch = 0;
    int tests_run = 0;
    cfe_op_type ops [7] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_RLF, OP_RRF};
    // Own encoding: bit 11 branch, else op, literal, dest, file
    assign dec_branch = instruction_latch[11];
    assign dec_target = instruction_latch[8:0];
    assign dec_op = dec_branch ? OP_NONE : cfe_op_type'(instruction_latch[10:7]);
    assign dec_use_literal = instruction_latch[6] & ~dec_branch;
    assign dec_dest_file = instruction_latch[5] & ~dec_branch;
    assign dec_literal = {3'h0, instruction_latch[4:0]};
    assign dec_affects_flags = (dec_op == OP_ADD) || (dec_op == OP_SUB);
    cfe_core dut (.clk(clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
        .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
        .data_rd(data_rd), .data_rdata(data_rdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .dec_op(dec_op), .dec_use_literal(dec_use_literal),
        .dec_literal(dec_literal), .dec_dest_file(dec_dest_file),
        .dec_affects_flags(dec_affects_flags), .dec_branch(dec_branch),
        .dec_target(dec_target), .rc_mode(rc_mode), .timer_zero_count(timer_zero_count),
        .osc_output_clock_out(osc_output_clock_out), .insn_file_addr(),
        .instruction_latch(instruction_latch), .working_register(working_register),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .phase(phase));
    cfe_mem_model u_mem (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd),
        .data_rdata(data_rdata), .data_wr(data_wr), .data_wdata(data_wdata));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic cfe_phase_type nxt_ph(cfe_phase_type p);
        case (p)
            PH_ONE: return PH_TWO;
            PH_TWO: return PH_THREE;
            PH_THREE: return PH_FOUR;
            default: return PH_ONE;
        endcase
    endfunction
    task automatic load_regs();
        for (int j = 0; j < 32; j++) begin
            mr[j] = xs();
            u_mem.regs[j] = mr[j];
        end
    endtask
    task automatic gen_prog();
        logic [31:0] r;
        logic [4:0] fa;
        for (int i = 0; i < 512; i++) u_mem.rom[i] = INSN_NOP;
        for (int i = 0; i < 40; i++) begin
            r = xs();
            fa = (r[13:11] == 3'h0) ? ADDR_PCL : (r[13:11] == 3'h1) ? ADDR_STATUS :
                 5'(8 + r[20:16] % 24);
            u_mem.rom[i] = {1'b0, ops[r % 7], r[8], r[9] & ~r[8] & (fa > 5'h07), fa};
        end
        // Forward branch with a write behind it that must never land
        u_mem.rom[20] = {3'h4, 9'h01e};
        u_mem.rom[21] = {1'b0, OP_IOR, 1'b0, 1'b1, 5'h10};
        u_mem.rom[40] = {3'h4, 9'h028};
    endtask
    // Reference run from address 000h, after the no-op at the reset vector
    task automatic run_iss();
        logic [PC_W-1:0] pc;
        logic [INSN_W-1:0] ins;
        logic [DATA_W-1:0] a, b, f, r;
        logic [8:0] s;
        pc = '0;
        ew = '0;
        // Flags survive master clear, so the model carries them across runs
        for (int k = 0; k < 80; k++) begin
            ins = u_mem.rom[pc];
            if (ins[11]) begin
                if (ins[8:0] == pc) break;
                pc = ins[8:0];
                continue;
            end
            f = (ins[4:0] == ADDR_PCL) ? 8'(pc + 9'h001) :
                (ins[4:0] == ADDR_STATUS) ? {5'h00, ez, edc, ec} : mr[ins[4:0]];
            a = ins[6] ? {3'h0, ins[4:0]} : ew;
            b = ins[6] ? ew : f;
            r = b;
            case (cfe_op_type'(ins[10:7]))
                OP_ADD: begin
                    s = {1'b0, b} + {1'b0, a};
                    r = s[7:0];
                    {ec, edc, ez} = {s[8], ({1'b0, b[3:0]} + {1'b0, a[3:0]}) > 5'h0f, r == 8'h00};
                end
                OP_SUB: begin
                    r = b - a;
                    {ec, edc, ez} = {b >= a, b[3:0] >= a[3:0], r == 8'h00};
                end
                OP_AND: r = a & b;
                OP_IOR: r = a | b;
                OP_XOR: r = a ^ b;
                OP_RLF: r = {b[6:0], ec};
                OP_RRF: r = {ec, b[7:1]};
                default: r = b;
            endcase
            if (ins[5]) begin
                mr[ins[4:0]] = r;
                expq.push_back({ins[4:0], r});
            end else ew = r;
            pc = pc + 9'h001;
        end
    endtask
    task automatic end_check();
        repeat (400) @(posedge clk);
        #1;
        `CHK(expq.size(), 0);
        `CHK(working_register, ew);
        `CHK({carry_flag, digit_carry_flag, zero_flag}, {ec, edc, ez});
    endtask
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Every write is matched against the oldest expected note
    always @(posedge clk) begin
        if (data_wr === 1'b1) begin
            `CHK(expq.size() > 0, 1'b1);
            if (expq.size() > 0) begin
                wexp = expq.pop_front();
                `CHK({data_addr, data_wdata}, wexp);
            end
        end
    end
    initial begin
        #20000;
        n_mismatch++;
        test_done();
    end
    initial begin
        {rst_n, master_clear_n, rc_mode, timer_zero_count} = {1'b0, 1'b1, 1'b0, 8'h00};
        gen_prog();
        {ec, edc, ez} = 3'h0;
        load_regs();
        run_iss();
        repeat (8) @(posedge clk);
        #1;
        `CHK(prog_addr, RESET_VECTOR);
        rst_n = 1'b1;
        end_check();
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            #1;
            if (k > 0) begin
                `CHK(phase, nxt_ph(pprev));
                `CHK(osc_output_clock_out, (pprev == PH_THREE || pprev == PH_FOUR));
            end
            pprev = phase;
        end
        rc_mode = 1'b1;
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            #1;
            if (k > 1) `CHK(osc_output_clock_out, prev_t);
            timer_zero_count = 8'(xs());
            prev_t = timer_zero_count[0];
        end
        master_clear_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        `CHK(phase, PH_ONE);
        `CHK(prog_addr, RESET_VECTOR);
        `CHK(instruction_latch, INSN_NOP);
        load_regs();
        run_iss();
        master_clear_n = 1'b1;
        end_check();
        test_done();
    end
endmodule // tb_core_fetch_execute_pipeline
`default_nettype wire
